/* ctrl_reg_slice.sv */
// One 8-bit writable control register of the RF control bank.
// Assumes a synchronous active-low reset and a shared clock enable.
`timescale 1ns/1ps
`include "rf_ctrl_map.svh"
module ctrl_reg_slice #(
  parameter logic [1:0] INDEX = 2'h0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  ctrl_wr_if.dst wr,
  output logic [7:0] q
);
  rf_ctrl_pkg::slice_state_type st_r;
  rf_ctrl_pkg::slice_state_type st_nxt;

  // Load only on a write that names this register; otherwise hold
  always_comb begin
    st_nxt = st_r;
    if (wr.wr_en && (wr.wr_sel == INDEX)) begin
      st_nxt.value = wr.wr_data;
    end
  end

  // Reset wins over the clock enable so a frozen bank still clears
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_r.value <= `RFC_REG_RESET;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.value;

  property p_slice_hold;
    @(posedge core_clk) disable iff (!reset_n)
      !(clk_en && wr.wr_en && (wr.wr_sel == INDEX)) |=> $stable(q);
  endproperty
  a_slice_hold: assert property (p_slice_hold) else $error("slice changed without write");
endmodule

/* ctrl_wr_if.sv */
// Write port bundle from the bank top to its register slices.
// Assumes one clock domain; the source drives, every slice listens.
`timescale 1ns/1ps
interface ctrl_wr_if;
  logic wr_en;
  logic [1:0] wr_sel;
  logic [7:0] wr_data;
  modport src (output wr_en, output wr_sel, output wr_data);
  modport dst (input wr_en, input wr_sel, input wr_data);
endinterface

/* host_model.sv */
// Host processor model that issues register writes to the RF control bank.
// Assumes one clock; requests change after the falling edge and are taken at the rising edge.
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  output logic wr_en,
  output logic [1:0] wr_sel,
  output logic [7:0] wr_data
);
  // Idle bus at time zero
  initial begin
    wr_en = 1'b0;
    wr_sel = 2'h3;
    wr_data = 8'h00;
  end

  // One write request, held until the caller issues another or releases the bus
  task automatic put(input logic [1:0] sel, input logic [7:0] data);
    @(negedge core_clk);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = data;
  endtask

  // Released lines show the inverse of the last value so nothing stale looks valid
  task automatic release_bus();
    @(negedge core_clk);
    wr_en = 1'b0;
    wr_sel = ~wr_sel;
    wr_data = ~wr_data;
  endtask

  // Usual front end word: both insert lines high so the hardware sets attenuation itself
  function automatic logic [7:0] front_end_word(input logic [5:0] upper);
    return {upper, 2'b11};
  endfunction
endmodule

/* rf_control_register_bank.sv */
// RF control register bank: three 8-bit write-only control registers and irq routing.
// Assumes the write port comes from logic on core_clk; irq sources are asynchronous pins.
`timescale 1ns/1ps
`include "rf_ctrl_map.svh"
module rf_control_register_bank (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic serial_irq_src,
  input wire logic printer_irq_src,
  input wire logic keypad_irq_src,
  output logic if_bandwidth_sel_lo,
  output logic if_bandwidth_sel_hi,
  output logic rx_format_analog,
  output logic front_end_switch_first,
  output logic front_end_switch_second,
  output logic gen_rx_tie_en,
  output logic pm_range_a,
  output logic pm_range_b,
  output logic atten_first_insert_n,
  output logic atten_second_insert_n,
  output logic power_off,
  output logic backlight_off,
  output logic printer_port_en,
  output logic config_ee_out_en,
  output logic ee_clock,
  output logic ee_data,
  output logic [7:0] periph_ctrl,
  output logic irq4,
  output logic irq7,
  output logic irq10,
  output rf_ctrl_pkg::bw_mode_type rx_bw_mode,
  output rf_ctrl_pkg::fe_mode_type fe_mode,
  output rf_ctrl_pkg::pm_range_type pm_range,
  output rf_ctrl_pkg::atten_level_type atten_level
);
  ctrl_wr_if wr_bus ();
  logic [7:0] reg_q [`RFC_REG_COUNT];
  logic [7:0] reg_next [`RFC_REG_COUNT];
  logic [2:0] irq_src;
  rf_ctrl_pkg::bank_state_type st_r;
  rf_ctrl_pkg::bank_state_type st_nxt;

  // Host write port into the slice bundle
  assign wr_bus.wr_en = wr_en;
  assign wr_bus.wr_sel = wr_sel;
  assign wr_bus.wr_data = wr_data;
  assign irq_src = {keypad_irq_src, printer_irq_src, serial_irq_src};

  // One slice per control register; index 3 matches none and is ignored
  for (genvar gi = 0; gi < `RFC_REG_COUNT; gi++) begin : g_reg
    ctrl_reg_slice #(
      .INDEX(2'(gi))
    ) u_slice (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .wr(wr_bus),
      .q(reg_q[gi])
    );
    // Value the slice takes at the coming edge, so decodes line up with it
    assign reg_next[gi] = (wr_en && (wr_sel == 2'(gi))) ? wr_data : reg_q[gi];
  end

  // Decodes are computed from the next register values, so they change on the same edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.irq_s1 = irq_src;
    st_nxt.irq_s2 = st_r.irq_s1;
    st_nxt.irq_out = st_r.irq_s2;
    st_nxt.bw = rf_ctrl_pkg::bw_mode_type'({reg_next[0][`RFC_BIT_BW_HI],
                                            reg_next[0][`RFC_BIT_BW_LO]});
    st_nxt.fe = rf_ctrl_pkg::fe_mode_type'({reg_next[0][`RFC_BIT_SW_FIRST],
                                            reg_next[0][`RFC_BIT_SW_SECOND]});
    st_nxt.pm = rf_ctrl_pkg::pm_range_type'({reg_next[0][`RFC_BIT_PM_A],
                                             reg_next[0][`RFC_BIT_PM_B]});
    // Gated by the switch mode: a stray host bit cannot tie the generator in normal mode
    st_nxt.tie_en = reg_next[0][`RFC_BIT_TIE_EN] &&
                    (st_nxt.fe != rf_ctrl_pkg::FE_NORMAL);
    // Second section low forces 60 dB whatever the first line says
    if (!reg_next[1][`RFC_BIT_ATT2_N]) begin
      st_nxt.att = rf_ctrl_pkg::ATT_60DB;
    end else if (!reg_next[1][`RFC_BIT_ATT1_N]) begin
      st_nxt.att = rf_ctrl_pkg::ATT_30DB;
    end else begin
      st_nxt.att = rf_ctrl_pkg::ATT_0DB;
    end
  end

  // All-zero reset also gives the all-low decode codes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Register bits drive the lines straight from the slice flops
  assign if_bandwidth_sel_lo = reg_q[0][`RFC_BIT_BW_LO];
  assign if_bandwidth_sel_hi = reg_q[0][`RFC_BIT_BW_HI];
  assign rx_format_analog = reg_q[0][`RFC_BIT_RX_ANALOG];
  assign front_end_switch_first = reg_q[0][`RFC_BIT_SW_FIRST];
  assign front_end_switch_second = reg_q[0][`RFC_BIT_SW_SECOND];
  assign pm_range_a = reg_q[0][`RFC_BIT_PM_A];
  assign pm_range_b = reg_q[0][`RFC_BIT_PM_B];
  assign atten_first_insert_n = reg_q[1][`RFC_BIT_ATT1_N];
  assign atten_second_insert_n = reg_q[1][`RFC_BIT_ATT2_N];
  assign power_off = reg_q[1][`RFC_BIT_PWR_OFF];
  assign backlight_off = reg_q[1][`RFC_BIT_BKLT_OFF];
  assign printer_port_en = reg_q[1][`RFC_BIT_PRN_EN];
  assign config_ee_out_en = reg_q[1][`RFC_BIT_CFG_EE_EN];
  assign ee_clock = reg_q[1][`RFC_BIT_EE_CLK];
  assign ee_data = reg_q[1][`RFC_BIT_EE_DATA];
  assign periph_ctrl = reg_q[2];

  // Decoded and synchronised outputs come from the bank state flops
  assign gen_rx_tie_en = st_r.tie_en;
  assign rx_bw_mode = st_r.bw;
  assign fe_mode = st_r.fe;
  assign pm_range = st_r.pm;
  assign atten_level = st_r.att;
  assign irq4 = st_r.irq_out[0];
  assign irq7 = st_r.irq_out[1];
  assign irq10 = st_r.irq_out[2];

  // Checks

  sequence s_wr_rx;
    clk_en && wr_en && (wr_sel == `RFC_IDX_RX);
  endsequence

  sequence s_wr_fe;
    clk_en && wr_en && (wr_sel == `RFC_IDX_FE);
  endsequence

  property p_reset_low;
    @(posedge core_clk) !reset_n |=> (reg_q[0] == 8'h00) && (reg_q[1] == 8'h00) &&
      (reg_q[2] == 8'h00) && !gen_rx_tie_en && !irq4 && !irq7 && !irq10;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("outputs not low after reset");

  property p_bw_decode;
    @(posedge core_clk) disable iff (!reset_n)
      (rx_bw_mode == rf_ctrl_pkg::BW_300K) == (if_bandwidth_sel_lo && if_bandwidth_sel_hi) &&
      (rx_bw_mode == rf_ctrl_pkg::BW_30K) == (if_bandwidth_sel_lo && !if_bandwidth_sel_hi) &&
      (rx_bw_mode == rf_ctrl_pkg::BW_200K) == (!if_bandwidth_sel_lo && if_bandwidth_sel_hi);
  endproperty
  a_bw_decode: assert property (p_bw_decode) else $error("bandwidth decode mismatch");

  property p_rx_format;
    @(posedge core_clk) disable iff (!reset_n)
      s_wr_rx |=> rx_format_analog == $past(wr_data[`RFC_BIT_RX_ANALOG]);
  endproperty
  a_rx_format: assert property (p_rx_format) else $error("receiver format not loaded");

  property p_fe_decode;
    @(posedge core_clk) disable iff (!reset_n)
      s_wr_fe or s_wr_rx |=> (fe_mode == rf_ctrl_pkg::FE_CABLE_REF) ==
        (front_end_switch_first && front_end_switch_second) &&
      (fe_mode == rf_ctrl_pkg::FE_SELFTEST) ==
        (!front_end_switch_first && front_end_switch_second) &&
      (fe_mode == rf_ctrl_pkg::FE_CABLE_MEAS) ==
        (front_end_switch_first && !front_end_switch_second);
  endproperty
  a_fe_decode: assert property (p_fe_decode) else $error("front end mode decode mismatch");

  property p_tie_normal;
    @(posedge core_clk) disable iff (!reset_n)
      s_wr_rx ##1 (fe_mode != rf_ctrl_pkg::FE_NORMAL) |->
        gen_rx_tie_en == reg_q[0][`RFC_BIT_TIE_EN];
  endproperty
  a_tie_normal: assert property (p_tie_normal) else $error("tie enable not following bit");

  property p_tie_low;
    @(posedge core_clk) disable iff (!reset_n)
      (fe_mode == rf_ctrl_pkg::FE_NORMAL) |-> !gen_rx_tie_en;
  endproperty
  a_tie_low: assert property (p_tie_low) else $error("tie enable high in normal mode");

  property p_pm_decode;
    @(posedge core_clk) disable iff (!reset_n)
      (pm_range == rf_ctrl_pkg::PM_LOW) == (!pm_range_a && pm_range_b) &&
      (pm_range == rf_ctrl_pkg::PM_MED) == (pm_range_a && !pm_range_b) &&
      (pm_range == rf_ctrl_pkg::PM_HIGH) == (!pm_range_a && !pm_range_b);
  endproperty
  a_pm_decode: assert property (p_pm_decode) else $error("meter range decode mismatch");

  property p_att30;
    @(posedge core_clk) disable iff (!reset_n)
      s_wr_fe ##1 (atten_second_insert_n && !atten_first_insert_n) |->
        atten_level == rf_ctrl_pkg::ATT_30DB;
  endproperty
  a_att30: assert property (p_att30) else $error("30 dB insert not decoded");

  property p_att60;
    @(posedge core_clk) disable iff (!reset_n)
      !atten_second_insert_n |-> atten_level == rf_ctrl_pkg::ATT_60DB;
  endproperty
  a_att60: assert property (p_att60) else $error("60 dB insert not decoded");

  // Each source must reach its own output after three enabled edges
  for (genvar gj = 0; gj < 3; gj++) begin : g_irq_chk
    property p_irq_route;
      @(posedge core_clk) disable iff (!reset_n)
        (clk_en && irq_src[gj])[*3] |=> st_r.irq_out[gj];
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("irq source not routed");
  end

  property p_unmapped;
    @(posedge core_clk) disable iff (!reset_n)
      (wr_en && (wr_sel == 2'h3)) |=> $stable(reg_q[0]) && $stable(reg_q[1]) &&
        $stable(reg_q[2]);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed a register");

  property p_freeze;
    @(posedge core_clk) disable iff (!reset_n)
      !clk_en |=> $stable(st_r) && $stable(reg_q[0]) && $stable(reg_q[1]) &&
        $stable(periph_ctrl);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  property p_periph_load;
    @(posedge core_clk) disable iff (!reset_n)
      (clk_en && wr_en && (wr_sel == `RFC_IDX_PERIPH)) |=> periph_ctrl == $past(wr_data);
  endproperty
  a_periph_load: assert property (p_periph_load) else $error("third register not loaded");
endmodule

/* rf_control_register_bank_test.sv */
// Self-checking bench for the RF control register bank.
// Assumes host_model.sv and the design files are compiled first.
`timescale 1ns/1ps
module rf_control_register_bank_test;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b0;
  logic serial_irq_src = 1'b0;
  logic printer_irq_src = 1'b0;
  logic keypad_irq_src = 1'b0;
  logic wr_en;
  logic [1:0] wr_sel;
  logic [7:0] wr_data;
  logic if_bandwidth_sel_lo, if_bandwidth_sel_hi, rx_format_analog, front_end_switch_first;
  logic front_end_switch_second, gen_rx_tie_en, pm_range_a, pm_range_b, atten_first_insert_n;
  logic atten_second_insert_n, power_off, backlight_off, printer_port_en, config_ee_out_en;
  logic ee_clock, ee_data, irq4, irq7, irq10;
  logic [7:0] periph_ctrl;
  rf_ctrl_pkg::bw_mode_type rx_bw_mode;
  rf_ctrl_pkg::fe_mode_type fe_mode;
  rf_ctrl_pkg::pm_range_type pm_range;
  rf_ctrl_pkg::atten_level_type atten_level;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] note_q[$];
  logic [7:0] exp_r[3] = '{8'h00, 8'h00, 8'h00};
  logic [15:0] lfsr_r = 16'h6a9d;
  logic [2:0] irq_old = 3'h0;
  logic [7:0] d;
  wire [31:0] seen = {pm_range_b, pm_range_a, gen_rx_tie_en, front_end_switch_second,
    front_end_switch_first, rx_format_analog, if_bandwidth_sel_hi, if_bandwidth_sel_lo,
    ee_data, ee_clock, config_ee_out_en, printer_port_en, backlight_off, power_off,
    atten_second_insert_n, atten_first_insert_n, periph_ctrl, rx_bw_mode, fe_mode,
    pm_range, atten_level};

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  host_model i_host_model (.core_clk(core_clk), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data));

  rf_control_register_bank i_rf_control_register_bank (.core_clk(core_clk),
    .reset_n(reset_n), .clk_en(clk_en), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .serial_irq_src(serial_irq_src), .printer_irq_src(printer_irq_src),
    .keypad_irq_src(keypad_irq_src), .if_bandwidth_sel_lo(if_bandwidth_sel_lo),
    .if_bandwidth_sel_hi(if_bandwidth_sel_hi), .rx_format_analog(rx_format_analog),
    .front_end_switch_first(front_end_switch_first),
    .front_end_switch_second(front_end_switch_second), .gen_rx_tie_en(gen_rx_tie_en),
    .pm_range_a(pm_range_a), .pm_range_b(pm_range_b),
    .atten_first_insert_n(atten_first_insert_n), .atten_second_insert_n(atten_second_insert_n),
    .power_off(power_off), .backlight_off(backlight_off), .printer_port_en(printer_port_en),
    .config_ee_out_en(config_ee_out_en), .ee_clock(ee_clock), .ee_data(ee_data),
    .periph_ctrl(periph_ctrl), .irq4(irq4), .irq7(irq7), .irq10(irq10),
    .rx_bw_mode(rx_bw_mode), .fe_mode(fe_mode), .pm_range(pm_range),
    .atten_level(atten_level));

  // Pseudo-random byte from a 16-bit shift register
  function automatic logic [7:0] rand8();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r[7:0];
  endfunction

  // Expected output picture, built from the line tables rather than the design's decode
  function automatic logic [31:0] snap_exp(input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] c);
    logic [1:0] bw, fe, pm, at;
    logic tie;
    case ({a[0], a[1]})
      2'b00: bw = rf_ctrl_pkg::BW_10K;
      2'b10: bw = rf_ctrl_pkg::BW_30K;
      2'b01: bw = rf_ctrl_pkg::BW_200K;
      default: bw = rf_ctrl_pkg::BW_300K;
    endcase
    case ({a[3], a[4]})
      2'b00: fe = rf_ctrl_pkg::FE_NORMAL;
      2'b01: fe = rf_ctrl_pkg::FE_SELFTEST;
      2'b10: fe = rf_ctrl_pkg::FE_CABLE_MEAS;
      default: fe = rf_ctrl_pkg::FE_CABLE_REF;
    endcase
    case ({a[6], a[7]})
      2'b01: pm = rf_ctrl_pkg::PM_LOW;
      2'b10: pm = rf_ctrl_pkg::PM_MED;
      2'b00: pm = rf_ctrl_pkg::PM_HIGH;
      default: pm = rf_ctrl_pkg::PM_OFF;
    endcase
    // Second insert line wins over the first
    if (!b[1]) at = rf_ctrl_pkg::ATT_60DB;
    else if (!b[0]) at = rf_ctrl_pkg::ATT_30DB;
    else at = rf_ctrl_pkg::ATT_0DB;
    // Tie request only counts outside normal mode
    tie = a[5] & (a[3] | a[4]);
    return {a[7:6], tie, a[4:0], b, c, bw, fe, pm, at};
  endfunction

  // Comparison of the whole output picture
  task automatic compare_word(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("unexpected outputs at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // Comparison of the three interrupt lines
  task automatic compare_irq(input logic [2:0] got, input logic [2:0] want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("unexpected irq at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // Write through the host model and note the picture that must follow it
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    if (clk_en && sel != 2'h3) exp_r[sel] = data;
    note_q.push_back(snap_exp(exp_r[0], exp_r[1], exp_r[2]));
    i_host_model.put(sel, data);
  endtask

  // Exact latency: old level after two edges, new level after the third
  task automatic irq_step(input logic [2:0] v);
    @(negedge core_clk);
    {keypad_irq_src, printer_irq_src, serial_irq_src} = v;
    repeat (2) @(posedge core_clk);
    #5 compare_irq({irq10, irq7, irq4}, irq_old);
    @(posedge core_clk);
    #5 compare_irq({irq10, irq7, irq4}, v);
    irq_old = v;
  endtask

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Every taken or refused write shows its result one edge later
  initial forever begin
    @(posedge core_clk);
    if (wr_en === 1'b1 && reset_n === 1'b1) begin
      #5;
      if (note_q.size() == 0) compare_word(seen, 32'hffffffff);
      else compare_word(seen, note_q.pop_front());
    end
  end

  // Cut a hang short
  initial begin
    #200000;
    failures++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    clk_en = 1'b1;
    wr(2'h3, rand8());
    // Every receiver register code, back to back
    for (int k = 0; k < 256; k++) wr(2'h0, k[7:0]);
    for (int k = 0; k < 4; k++) begin
      d = rand8();
      wr(2'h1, {d[7:2], k[1:0]});
    end
    wr(2'h1, i_host_model.front_end_word(d[5:0]));
    wr(2'h2, rand8());
    wr(2'h2, rand8());
    wr(2'h3, rand8());
    i_host_model.release_bus();
    repeat (5) @(negedge core_clk);
    wr(2'h3, 8'h00);
    i_host_model.release_bus();
    // Writes with the clock enable low must be dropped
    clk_en = 1'b0;
    wr(2'h0, rand8());
    i_host_model.release_bus();
    clk_en = 1'b1;
    wr(2'h3, rand8());
    i_host_model.release_bus();
    irq_step(3'b001);
    irq_step(3'b010);
    irq_step(3'b100);
    irq_step(3'b111);
    irq_step(3'b000);
    // Reset in mid-run clears every line
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    exp_r = '{8'h00, 8'h00, 8'h00};
    wr(2'h3, rand8());
    i_host_model.release_bus();
    repeat (2) @(negedge core_clk);
    summarize();
  end
endmodule

/* rf_ctrl_map.svh */
// Register indexes, bit positions, reset values and timing counts of the RF control bank.
// Assumes inclusion by bare name from any file that needs the bank layout.
`ifndef RF_CTRL_MAP_SVH
`define RF_CTRL_MAP_SVH

// Register indexes on the write port
`define RFC_IDX_RX      2'h0
`define RFC_IDX_FE      2'h1
`define RFC_IDX_PERIPH  2'h2
`define RFC_REG_COUNT   3

// Receiver register bit positions
`define RFC_BIT_BW_LO      0
`define RFC_BIT_BW_HI      1
`define RFC_BIT_RX_ANALOG  2
`define RFC_BIT_SW_FIRST   3
`define RFC_BIT_SW_SECOND  4
`define RFC_BIT_TIE_EN     5
`define RFC_BIT_PM_A       6
`define RFC_BIT_PM_B       7

// Front end and supply register bit positions
`define RFC_BIT_ATT1_N     0
`define RFC_BIT_ATT2_N     1
`define RFC_BIT_PWR_OFF    2
`define RFC_BIT_BKLT_OFF   3
`define RFC_BIT_PRN_EN     4
`define RFC_BIT_CFG_EE_EN  5
`define RFC_BIT_EE_CLK     6
`define RFC_BIT_EE_DATA    7

// Every control line comes out of reset low
`define RFC_REG_RESET   8'h00

// Interrupt synchroniser stages ahead of the output flop; source to output takes three enabled edges
`define RFC_IRQ_SYNC_STAGES 2

`endif

/* rf_ctrl_pkg.sv */
// Types shared by the RF control bank and its register slices.
// Assumes rf_ctrl_map.svh supplies the numeric layout.
package rf_ctrl_pkg;

  // Decoded IF bandwidth, code is {sel_hi, sel_lo}
  typedef enum logic [1:0] {
    BW_10K  = 2'b00,
    BW_30K  = 2'b01,
    BW_200K = 2'b10,
    BW_300K = 2'b11
  } bw_mode_type;

  // Decoded front end switch mode, code is {first, second}
  typedef enum logic [1:0] {
    FE_NORMAL    = 2'b00,
    FE_SELFTEST  = 2'b01,
    FE_CABLE_MEAS = 2'b10,
    FE_CABLE_REF = 2'b11
  } fe_mode_type;

  // Decoded power meter range, code is {range_a, range_b}
  typedef enum logic [1:0] {
    PM_HIGH = 2'b00,
    PM_LOW  = 2'b01,
    PM_MED  = 2'b10,
    PM_OFF  = 2'b11
  } pm_range_type;

  // Receive attenuation that the insert lines request
  typedef enum logic [1:0] {
    ATT_60DB = 2'b00,
    ATT_30DB = 2'b01,
    ATT_0DB  = 2'b10
  } atten_level_type;

  typedef struct packed {
    logic [7:0] value;
  } slice_state_type;

  typedef struct packed {
    logic [2:0] irq_s1;
    logic [2:0] irq_s2;
    logic [2:0] irq_out;
    logic tie_en;
    bw_mode_type bw;
    fe_mode_type fe;
    pm_range_type pm;
    atten_level_type att;
  } bank_state_type;

endpackage
